// *** core/uhd_timing_pkg.sv ***
// Shared constants for the panel video timing link and both of its ends
package uhd_timing_pkg;
    localparam int CLK_MHZ = 200;
    localparam int PIX_W = 30;
    localparam int LANES = 8;
    localparam int HALF_LANES = 4;
    localparam int H_W = 10;
    localparam int V_W = 12;
    localparam int GAP_W = 13;
    localparam int CNT_W = 20;
    // Active area in clock groups: 1920 pixels per half over 4 lanes
    localparam logic [H_W-1:0] H_ACT = 10'h1e0;
    localparam logic [V_W-1:0] V_ACT = 12'h870;
    localparam logic [H_W-1:0] H_TOTAL_TYP = 10'h226;
    localparam logic [V_W-1:0] V_TOTAL_TYP = 12'h8ca;
    localparam logic [GAP_W-1:0] FRAME_GAP_LINES = 13'h0008;
    // Link timing in microseconds and in clock cycles
    localparam int TRAIN_US = 500;
    localparam int L1_US = 1;
    localparam int L2_TYP_US = 1;
    localparam int L2_MAX_US = 70;
    localparam int TRAIN_CYCLES = TRAIN_US * CLK_MHZ;
    localparam int L2_TYP_CYCLES = L2_TYP_US * CLK_MHZ;
    localparam int L2_MAX_CYCLES = L2_MAX_US * CLK_MHZ;
    localparam int L1_CYCLES = L1_US * CLK_MHZ;
    localparam int LOCK_CYCLES_DEF = 1024;
    localparam logic [LANES*PIX_W-1:0] BLACK = '0;
endpackage : uhd_timing_pkg

// *** core/uhd_link_if.sv ***
// Link between the video source and the panel receiver
`timescale 1ns/1ps
`default_nettype none
interface uhd_link_if;
    logic active_video_qualifier;
    logic training_pattern;
    logic [uhd_timing_pkg::LANES*uhd_timing_pkg::PIX_W-1:0] lane_data;
    logic link_lock_status_n;
    modport source (
        output active_video_qualifier,
        output training_pattern,
        output lane_data,
        input link_lock_status_n
    );
    modport panel (
        input active_video_qualifier,
        input training_pattern,
        input lane_data,
        output link_lock_status_n
    );
endinterface : uhd_link_if
`default_nettype wire

// *** core/uhd_video_source.sv ***
// Video source end: link training response and raster generation
`timescale 1ns/1ps
`default_nettype none
module uhd_video_source #(
    parameter int TRAIN_CYCLES = uhd_timing_pkg::TRAIN_CYCLES,
    parameter int L2_CYCLES = uhd_timing_pkg::L2_TYP_CYCLES,
    parameter logic [uhd_timing_pkg::H_W-1:0] H_TOTAL = uhd_timing_pkg::H_TOTAL_TYP,
    parameter logic [uhd_timing_pkg::V_W-1:0] V_TOTAL = uhd_timing_pkg::V_TOTAL_TYP
) (
    input wire logic SYS_CLK_I,                                   // System and pixel clock
    input wire logic RSTN_I,                                      // Synchronous reset, low
    input wire logic POWER_ON_I,                                  // Panel supply is on
    input wire logic [uhd_timing_pkg::HALF_LANES*uhd_timing_pkg::PIX_W-1:0] LEFT_DATA_I,  // Left
    input wire logic [uhd_timing_pkg::HALF_LANES*uhd_timing_pkg::PIX_W-1:0] RIGHT_DATA_I, // Right
    output logic PIX_REQ_O,                                       // Data taken this cycle
    output logic LINK_UP_O,                                       // Sending normal data
    output logic TRAIN_TIMEOUT_O,                                 // Training overran
    uhd_link_if.source link                                       // Serial link
);
    localparam int CW = uhd_timing_pkg::CNT_W;
    localparam int HW = uhd_timing_pkg::H_W;
    localparam int VW = uhd_timing_pkg::V_W;

    typedef enum logic [3:0] {
        S_OFF = 4'b0001,
        S_TRAIN = 4'b0010,
        S_WAIT = 4'b0100,
        S_DATA = 4'b1000
    } src_state_e;

    src_state_e state_reg;
    src_state_e state_next;
    logic [CW-1:0] cnt_reg;
    logic [HW-1:0] h_reg;
    logic [VW-1:0] v_reg;
    logic [HW-1:0] h_next;
    logic [VW-1:0] v_next;
    logic qual_reg;
    logic train_reg;
    logic [uhd_timing_pkg::LANES*uhd_timing_pkg::PIX_W-1:0] data_reg;

    assign link.active_video_qualifier = qual_reg;
    assign link.training_pattern = train_reg;
    assign link.lane_data = data_reg;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            S_OFF:
                if (POWER_ON_I) state_next = S_TRAIN;
            S_TRAIN:
                if (!link.link_lock_status_n) state_next = S_WAIT;
            S_WAIT:
                if (link.link_lock_status_n) state_next = S_TRAIN;   // [RQ13]
                else if (cnt_reg == CW'(L2_CYCLES - 1)) state_next = S_DATA; // [RQ10]
            S_DATA:
                if (link.link_lock_status_n) state_next = S_TRAIN;   // [RQ9] [RQ13]
        endcase
        if (!POWER_ON_I) state_next = S_OFF;
    end

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I) state_reg <= S_OFF;
        else state_reg <= state_next;

    // Training length and post-lock delay share one counter
    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I || state_next != state_reg) cnt_reg <= '0;
        else if (cnt_reg != {CW{1'b1}}) cnt_reg <= cnt_reg + 1'b1;

    // Training pattern lasting past its nominal time is flagged, not aborted
    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I || state_reg != S_TRAIN) TRAIN_TIMEOUT_O <= 1'b0;
        else if (cnt_reg >= CW'(TRAIN_CYCLES - 1)) TRAIN_TIMEOUT_O <= 1'b1; // [RQ8]

    // Raster counters; frame blanking of V_TOTAL-V_ACT lines exceeds eight
    always_comb
    begin
        h_next = h_reg + 1'b1;
        v_next = v_reg;
        if (h_reg == H_TOTAL - 1'b1)                         // [RQ6]
        begin
            h_next = '0;
            v_next = (v_reg == V_TOTAL - 1'b1) ? '0 : v_reg + 1'b1; // [RQ3] [RQ6]
        end
        if (state_reg != S_DATA)
        begin
            h_next = '0;
            v_next = '0;
        end
    end

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I)
        begin
            h_reg <= '0;
            v_reg <= '0;
        end
        else
        begin
            h_reg <= h_next;
            v_reg <= v_next;
        end

    // Request is issued one cycle ahead so the qualifier and data flop together
    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I) PIX_REQ_O <= 1'b0;
        else PIX_REQ_O <= (state_next == S_DATA)
            && (h_next < uhd_timing_pkg::H_ACT) && (v_next < uhd_timing_pkg::V_ACT);

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I)
        begin
            qual_reg <= 1'b0;
            data_reg <= uhd_timing_pkg::BLACK;
        end
        else if (PIX_REQ_O && state_next == S_DATA)
        begin
            qual_reg <= 1'b1;                                // [RQ5]
            data_reg <= {RIGHT_DATA_I, LEFT_DATA_I};         // [RQ7]
        end
        else
        begin
            qual_reg <= 1'b0;                                // [RQ11]
            data_reg <= uhd_timing_pkg::BLACK;
        end

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I) train_reg <= 1'b0;
        else train_reg <= (state_next == S_TRAIN) || (state_next == S_WAIT); // [RQ9] [RQ11]

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I) LINK_UP_O <= 1'b0;
        else LINK_UP_O <= (state_next == S_DATA);
endmodule : uhd_video_source
`default_nettype wire

// *** core/uhd_panel_rx.sv ***
// Panel receiver end: lock handshake and qualifier-only raster recovery
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RQ1] Position comes only from qualifier rises
// [RQ2] First pixel after rise is left edge
// [RQ3] Rise after eight low lines starts frame
// [RQ4] Short lines or frames filled with black
// [RQ5] Source aligns qualifier with valid data
// [RQ6] Source keeps line and frame period limits
// [RQ7] Lanes 1-4 left half, 5-8 right
// [RQ8] Source trains about 500 us
// [RQ9] Source trains within 1 us of unlock
// [RQ10] Source sends data within 70 us of lock
// [RQ11] Source drives everything low when unpowered
// [RQ12] Lock status high until all lanes aligned
// [RQ13] Source retrains whenever lock status rises
module uhd_panel_rx #(
    parameter int LOCK_CYCLES = uhd_timing_pkg::LOCK_CYCLES_DEF
) (
    input wire logic SYS_CLK_I,                                   // System and pixel clock
    input wire logic RSTN_I,                                      // Synchronous reset, low
    input wire logic LINK_FAULT_I,                                // Lane alignment lost
    output logic LOCKED_O,                                        // Receiver is locked
    output logic PIX_VALID_O,                                     // Pixel group valid
    output logic FRAME_START_O,                                   // Top-left pixel pulse
    output logic [uhd_timing_pkg::H_W-1:0] COL_O,                 // Group column 0..479
    output logic [uhd_timing_pkg::V_W-1:0] ROW_O,                 // Line 0..2159
    output logic [uhd_timing_pkg::HALF_LANES*uhd_timing_pkg::PIX_W-1:0] LEFT_PIX_O,  // Left
    output logic [uhd_timing_pkg::HALF_LANES*uhd_timing_pkg::PIX_W-1:0] RIGHT_PIX_O, // Right
    uhd_link_if.panel link                                        // Serial link
);
    localparam int HW = uhd_timing_pkg::H_W;
    localparam int VW = uhd_timing_pkg::V_W;
    localparam int GW = uhd_timing_pkg::GAP_W;
    localparam int CW = uhd_timing_pkg::CNT_W;
    localparam int HPW = uhd_timing_pkg::HALF_LANES * uhd_timing_pkg::PIX_W;
    localparam logic [HW-1:0] H_LAST = uhd_timing_pkg::H_ACT - 1'b1;
    localparam logic [VW-1:0] V_LAST = uhd_timing_pkg::V_ACT - 1'b1;

    typedef enum logic [1:0] {
        LK_HUNT = 2'b01,
        LK_DONE = 2'b10
    } lock_state_e;

    typedef enum logic [3:0] {
        VS_BLANK = 4'b0001,
        VS_ACTIVE = 4'b0010,
        VS_HFILL = 4'b0100,
        VS_VFILL = 4'b1000
    } video_state_e;

    // Low time that marks a frame gap, saturating in the counter width
    function automatic logic [GW-1:0] gap_limit(input logic [HW-1:0] period);
        logic [GW+3:0] prod;
        prod = (GW+4)'(period) * (GW+4)'(uhd_timing_pkg::FRAME_GAP_LINES);
        gap_limit = (prod > (GW+4)'({GW{1'b1}})) ? {GW{1'b1}} : prod[GW-1:0];
    endfunction : gap_limit

    lock_state_e lock_reg;
    logic [CW-1:0] lock_cnt_reg;
    logic lock_n_reg;
    video_state_e vstate_reg;
    logic qual;
    logic qual_d_reg;
    logic rise;
    logic [HW-1:0] since_rise_reg;
    logic [HW-1:0] period_reg;
    logic [GW-1:0] low_cnt_reg;
    logic gap_reg;
    logic [HW-1:0] col_reg;
    logic [VW-1:0] row_reg;

    assign link.link_lock_status_n = lock_n_reg;

    // Lock needs an unbroken run of training pattern
    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I)
        begin
            lock_reg <= LK_HUNT;
            lock_cnt_reg <= '0;
        end
        else
        begin
            unique case (lock_reg)
                LK_HUNT:
                    if (!link.training_pattern || LINK_FAULT_I) lock_cnt_reg <= '0;
                    else if (lock_cnt_reg == CW'(LOCK_CYCLES - 1)) lock_reg <= LK_DONE;
                    else lock_cnt_reg <= lock_cnt_reg + 1'b1;
                LK_DONE:
                    if (LINK_FAULT_I)
                    begin
                        lock_reg <= LK_HUNT;
                        lock_cnt_reg <= '0;
                    end
            endcase
        end

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I) lock_n_reg <= 1'b1;
        else lock_n_reg <= !(lock_reg == LK_DONE && !LINK_FAULT_I);   // [RQ12]

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I) LOCKED_O <= 1'b0;
        else LOCKED_O <= (lock_reg == LK_DONE) && !LINK_FAULT_I;

    // Video is only trusted once locked and past training
    assign qual = link.active_video_qualifier && !lock_n_reg && !link.training_pattern;
    assign rise = qual && !qual_d_reg;                               // [RQ1]

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I) qual_d_reg <= 1'b0;
        else qual_d_reg <= qual;

    // Line period is learnt from rise to rise; no sync inputs exist to use
    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I)
        begin
            since_rise_reg <= '0;
            period_reg <= uhd_timing_pkg::H_TOTAL_TYP;
        end
        else if (rise)
        begin
            since_rise_reg <= '0;
            if (!gap_reg) period_reg <= since_rise_reg + 1'b1;       // [RQ1]
        end
        else if (since_rise_reg != {HW{1'b1}}) since_rise_reg <= since_rise_reg + 1'b1;

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I || qual) low_cnt_reg <= '0;
        else if (low_cnt_reg != {GW{1'b1}}) low_cnt_reg <= low_cnt_reg + 1'b1;

    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I) gap_reg <= 1'b0;
        else if (rise) gap_reg <= 1'b0;
        else if (low_cnt_reg >= gap_limit(period_reg)) gap_reg <= 1'b1; // [RQ3]

    // Raster walk; a rise overrides any fill in progress
    always_ff @(posedge SYS_CLK_I)
        if (!RSTN_I)
        begin
            vstate_reg <= VS_BLANK;
            col_reg <= '0;
            row_reg <= V_LAST;
            PIX_VALID_O <= 1'b0;
            FRAME_START_O <= 1'b0;
            COL_O <= '0;
            ROW_O <= '0;
            LEFT_PIX_O <= '0;
            RIGHT_PIX_O <= '0;
        end
        else
        begin
            PIX_VALID_O <= 1'b0;
            FRAME_START_O <= 1'b0;
            LEFT_PIX_O <= '0;
            RIGHT_PIX_O <= '0;
            if (rise)
            begin
                vstate_reg <= VS_ACTIVE;
                col_reg <= {{(HW-1){1'b0}}, 1'b1};
                row_reg <= gap_reg ? '0 : row_reg + 1'b1;           // [RQ3]
                FRAME_START_O <= gap_reg;
                PIX_VALID_O <= gap_reg || (row_reg < V_LAST);
                COL_O <= '0;                                         // [RQ2]
                ROW_O <= gap_reg ? '0 : row_reg + 1'b1;
                LEFT_PIX_O <= link.lane_data[HPW-1:0];               // [RQ7]
                RIGHT_PIX_O <= link.lane_data[2*HPW-1:HPW];
            end
            else
            begin
                unique case (vstate_reg)
                    VS_BLANK:
                        if (gap_reg && row_reg < V_LAST)
                        begin
                            vstate_reg <= VS_VFILL;                  // [RQ4]
                            row_reg <= row_reg + 1'b1;
                            col_reg <= '0;
                        end
                    VS_ACTIVE:
                        if (qual)
                        begin
                            PIX_VALID_O <= (col_reg <= H_LAST) && (row_reg <= V_LAST);
                            COL_O <= col_reg;
                            ROW_O <= row_reg;
                            LEFT_PIX_O <= link.lane_data[HPW-1:0];
                            RIGHT_PIX_O <= link.lane_data[2*HPW-1:HPW];
                            if (col_reg != {HW{1'b1}}) col_reg <= col_reg + 1'b1;
                        end
                        else if (col_reg <= H_LAST && row_reg <= V_LAST)
                        begin
                            vstate_reg <= VS_HFILL;                  // [RQ4]
                            PIX_VALID_O <= 1'b1;
                            COL_O <= col_reg;
                            ROW_O <= row_reg;
                            col_reg <= col_reg + 1'b1;
                            if (col_reg == H_LAST) vstate_reg <= VS_BLANK;
                        end
                        else vstate_reg <= VS_BLANK;
                    VS_HFILL:
                    begin
                        PIX_VALID_O <= 1'b1;                         // [RQ4]
                        COL_O <= col_reg;
                        ROW_O <= row_reg;
                        col_reg <= col_reg + 1'b1;
                        if (col_reg == H_LAST) vstate_reg <= VS_BLANK;
                    end
                    VS_VFILL:
                    begin
                        // Fill lines run back to back, faster than real lines
                        PIX_VALID_O <= 1'b1;                         // [RQ4]
                        COL_O <= col_reg;
                        ROW_O <= row_reg;
                        col_reg <= col_reg + 1'b1;
                        if (col_reg == H_LAST)
                        begin
                            col_reg <= '0;
                            if (row_reg == V_LAST) vstate_reg <= VS_BLANK;
                            else row_reg <= row_reg + 1'b1;
                        end
                    end
                endcase
            end
        end
endmodule : uhd_panel_rx
`default_nettype wire

// *** tb/uhd_link_sva.sv ***
// Checker for the link between the video source and the panel receiver
`timescale 1ns/1ps
`default_nettype none
module uhd_link_sva #(
    parameter int LOCK_CYCLES = 8,
    parameter int H_TOTAL = 550
) (
    input wire logic SYS_CLK_I, // Clock
    input wire logic RSTN_I, // Reset, low
    input wire logic active_video_qualifier, // Qualifier
    input wire logic training_pattern, // Training
    input wire logic [uhd_timing_pkg::LANES*uhd_timing_pkg::PIX_W-1:0] lane_data, // Lanes
    input wire logic link_lock_status_n // Lock status, low when locked
);
    logic [15:0] train_run_reg;
    logic [15:0] qual_run_reg;
    logic [15:0] since_rise_reg;
    logic qual_d_reg;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    // Counters saturate so a long idle link never wraps into a false pass
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I || !training_pattern) train_run_reg <= '0;
        else if (train_run_reg != 16'hffff) train_run_reg <= train_run_reg + 16'h0001;
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I || !active_video_qualifier) qual_run_reg <= '0;
        else if (qual_run_reg != 16'hffff) qual_run_reg <= qual_run_reg + 16'h0001;
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        qual_d_reg <= active_video_qualifier;
        if (!RSTN_I) since_rise_reg <= 16'hffff;
        else if (active_video_qualifier && !qual_d_reg) since_rise_reg <= 16'h0001;
        else if (since_rise_reg != 16'hffff) since_rise_reg <= since_rise_reg + 16'h0001;
    end

    AST_IDLE_ZERO: assert property (!active_video_qualifier |-> lane_data == '0)
        else $error("Lane data not zero outside active video");
    AST_TRAIN_NO_VIDEO: assert property (training_pattern |-> !active_video_qualifier)
        else $error("Active video during training");
    AST_QUAL_LOCKED: assert property ($rose(active_video_qualifier) |-> !link_lock_status_n)
        else $error("Video started while unlocked");
    AST_RETRAIN: assert property ($rose(link_lock_status_n) |-> ##2 (training_pattern && !active_video_qualifier))
        else $error("No retraining two cycles after unlock");
    AST_LOCK_AFTER_TRAIN: assert property ($fell(link_lock_status_n) |-> int'(train_run_reg) >= LOCK_CYCLES)
        else $error("Lock reported before enough training");
    AST_TRAIN_HOLD: assert property ($fell(link_lock_status_n) |-> training_pattern[*3])
        else $error("Training dropped too soon after lock");
    AST_QUAL_AFTER_LOCK: assert property ($fell(link_lock_status_n) |-> ##[1:16] $rose(active_video_qualifier))
        else $error("Video did not start after lock");
    AST_TRAIN_END: assert property ($fell(training_pattern) |-> !$past(link_lock_status_n, 3))
        else $error("Training ended without prior lock");
    AST_QUAL_RUN: assert property (qual_run_reg <= {6'h00, uhd_timing_pkg::H_ACT})
        else $error("Active run longer than a screen line");
    AST_LINE_PERIOD: assert property ($rose(active_video_qualifier) |-> int'(since_rise_reg) >= H_TOTAL)
        else $error("Line period shorter than programmed total");
endmodule : uhd_link_sva
`default_nettype wire

// *** tb/tb_uhd_panel_video_input_timing.sv ***
// Self-checking bench for both ends of the panel video link
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; $display("MISMATCH %s expected %0h seen %0h", nm, (exp), (got)); end end
module tb_uhd_panel_video_input_timing;
    localparam int HW = uhd_timing_pkg::HALF_LANES * uhd_timing_pkg::PIX_W;
    logic SYS_CLK_I = 1'b0;
    logic RSTN_I = 1'b0;
    logic POWER_ON_I = 1'b1;
    logic LINK_FAULT_I = 1'b0;
    logic [HW-1:0] LEFT_DATA_I = '0;
    logic [HW-1:0] RIGHT_DATA_I = '0;
    logic PIX_REQ_O, LINK_UP_O, TRAIN_TIMEOUT_O, LOCKED_O, PIX_VALID_O, FRAME_START_O;
    logic [uhd_timing_pkg::H_W-1:0] COL_O;
    logic [uhd_timing_pkg::V_W-1:0] ROW_O;
    logic [HW-1:0] LEFT_PIX_O, RIGHT_PIX_O;
    int error_cnt = 0;
    int tests_run = 0;
    int frames = 0;
    bit track = 1'b0;
    bit stop_line = 1'b0;
    logic [2*HW-1:0] sent_q[$];
    logic [2*HW-1:0] grp;
    logic [uhd_timing_pkg::H_W-1:0] exp_col = '0;
    logic [uhd_timing_pkg::V_W-1:0] exp_row = '0;

    uhd_link_if link_if();
    uhd_video_source #(.TRAIN_CYCLES(50), .L2_CYCLES(4)) uhd_video_source_inst (
        .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .POWER_ON_I(POWER_ON_I),
        .LEFT_DATA_I(LEFT_DATA_I), .RIGHT_DATA_I(RIGHT_DATA_I), .PIX_REQ_O(PIX_REQ_O),
        .LINK_UP_O(LINK_UP_O), .TRAIN_TIMEOUT_O(TRAIN_TIMEOUT_O), .link(link_if));
    uhd_panel_rx #(.LOCK_CYCLES(8)) uhd_panel_rx_inst (
        .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .LINK_FAULT_I(LINK_FAULT_I),
        .LOCKED_O(LOCKED_O), .PIX_VALID_O(PIX_VALID_O), .FRAME_START_O(FRAME_START_O),
        .COL_O(COL_O), .ROW_O(ROW_O), .LEFT_PIX_O(LEFT_PIX_O), .RIGHT_PIX_O(RIGHT_PIX_O),
        .link(link_if));
    uhd_link_sva #(.LOCK_CYCLES(8), .H_TOTAL(int'(uhd_timing_pkg::H_TOTAL_TYP))) uhd_link_sva_inst (
        .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I),
        .active_video_qualifier(link_if.active_video_qualifier),
        .training_pattern(link_if.training_pattern), .lane_data(link_if.lane_data),
        .link_lock_status_n(link_if.link_lock_status_n));

    initial
    begin
        forever #2.5 SYS_CLK_I = ~SYS_CLK_I;
    end

    function automatic logic [HW-1:0] rnd_half();
        logic [127:0] r;
        r = {$urandom, $urandom, $urandom, $urandom};
        return ($urandom_range(0, 15) == 0) ? '1 : r[HW-1:0];
    endfunction : rnd_half

    // Black is expected once the real groups already on the link are used up
    function automatic logic [2*HW-1:0] expect_group();
        return (sent_q.size() > 0) ? sent_q.pop_front() : '0;
    endfunction : expect_group

    // Forked from the seeded thread so the pixel stream follows the fixed seed
    task automatic drive_pixels();
        forever
        begin
            @(negedge SYS_CLK_I);
            LEFT_DATA_I = rnd_half();
            RIGHT_DATA_I = rnd_half();
        end
    endtask : drive_pixels

    always @(posedge SYS_CLK_I)
    begin
        if (RSTN_I && PIX_REQ_O && POWER_ON_I) sent_q.push_back({RIGHT_DATA_I, LEFT_DATA_I});
        if (RSTN_I && FRAME_START_O && !track)
        begin
            track = 1'b1;
            stop_line = 1'b0;
            exp_col = '0;
            exp_row = '0;
            frames++;
        end
        if (track && PIX_VALID_O)
        begin
            grp = expect_group();
            `CHK("col", COL_O, exp_col)
            `CHK("row", ROW_O, exp_row)
            `CHK("frame_pulse", FRAME_START_O, (exp_col == '0 && exp_row == '0))
            `CHK("left_pix", LEFT_PIX_O, grp[HW-1:0])
            `CHK("right_pix", RIGHT_PIX_O, grp[2*HW-1:HW])
            if (exp_col == 10'h1df)
            begin
                exp_col = '0;
                exp_row++;
                if (stop_line) track = 1'b0;
            end
            else exp_col++;
        end
    end

    task automatic check_up();
        repeat (200) if (LINK_UP_O !== 1'b1) @(negedge SYS_CLK_I);
        `CHK("locked", LOCKED_O, 1'b1)
        `CHK("lock_n", link_if.link_lock_status_n, 1'b0)
        `CHK("link_up", LINK_UP_O, 1'b1)
        `CHK("timeout", TRAIN_TIMEOUT_O, 1'b0)
    endtask : check_up

    // Cuts power mid-line, lets the short line fill, then waits out a frame gap
    // With vfill set the cut row is on screen, so black lines follow the gap
    task automatic power_cycle(input int lead, input bit vfill);
        int f0;
        stop_line = 1'b1;
        repeat (lead) @(negedge SYS_CLK_I);
        POWER_ON_I = 1'b0;
        @(negedge SYS_CLK_I);
        `CHK("link_off", {link_if.active_video_qualifier, link_if.training_pattern, link_if.lane_data}, '0)
        repeat (600) if (track) @(negedge SYS_CLK_I);
        `CHK("fill_done", track, 1'b0)
        sent_q.delete();
        repeat (4500) @(negedge SYS_CLK_I);
        `CHK("vfill", {PIX_VALID_O, LEFT_PIX_O, RIGHT_PIX_O}, {vfill, {(2*HW){1'b0}}})
        f0 = frames;
        POWER_ON_I = 1'b1;
        repeat (300) if (frames == f0) @(negedge SYS_CLK_I);
        `CHK("frame_start", frames, f0 + 1)
    endtask : power_cycle

    task automatic final_report();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    initial
    begin
        void'($urandom(32'ha6970bbc));
        fork
            drive_pixels();
        join_none
        repeat (3) @(negedge SYS_CLK_I);
        RSTN_I = 1'b1;
        check_up();
        repeat (1100) @(negedge SYS_CLK_I);
        power_cycle(10, 1'b0);
        repeat (1100) @(negedge SYS_CLK_I);
        power_cycle($urandom_range(50, 400), 1'b1);
        stop_line = 1'b1;
        repeat (600) if (track) @(negedge SYS_CLK_I);
        LINK_FAULT_I = 1'b1;
        repeat (70) @(negedge SYS_CLK_I);
        `CHK("fault_lock_n", link_if.link_lock_status_n, 1'b1)
        `CHK("fault_train", link_if.training_pattern, 1'b1)
        `CHK("fault_timeout", TRAIN_TIMEOUT_O, 1'b1)
        `CHK("fault_link_up", LINK_UP_O, 1'b0)
        LINK_FAULT_I = 1'b0;
        check_up();
        final_report();
    end

    initial
    begin
        repeat (40000) @(posedge SYS_CLK_I);
        error_cnt++;
        final_report();
    end
endmodule : tb_uhd_panel_video_input_timing
`default_nettype wire
